// *** shared/dsc_pkg.sv ***
// constants, field layouts and carriers for the disconnect status and control block
// assumes one core clock and a plain register port on the automation side
// Overview of operation
// - function enable cleared forces every output and indication inactive
// - substitution enabled presents the manually entered position instead of contacts
// - asserted close-block operand suppresses every close command
// - asserted open-block operand suppresses every open command
// - asserted local input inhibits open and close through the interlock path
// - three-pole mode derives position from one status input or pair
// - single-pole mode derives a position per phase from three inputs or pairs
// - closed taken from normally-open contact, open from normally-closed contact
// - operate timer runs while both indications are low, expiry flags bad status
// - in single-pole mode only, discrepancy timer runs while poles are neither all open nor all closed
// - counter-reset operand clears all operation counters of the switch
// - events enabled produces event records, disabled produces none
// - each switch holds a long name of up to 12 characters
// - each switch holds a short name of up to 8 characters
// - every switch instance has identical independent logic, settings, timers, counters
// - all logic is evaluated once per 50 ms automation scan
// - each scan samples inputs, then processes, then updates outputs
package dsc_pkg;

    localparam int DSC_N = 6;
    localparam int DSC_ADDR_W = 9;
    localparam int DSC_INST_LSB = 6;

    localparam int DSC_CLK_KHZ = 200000;
    localparam int DSC_SCAN_MS = 50;
    localparam int DSC_SCAN_CYCLES = DSC_SCAN_MS * DSC_CLK_KHZ;
    localparam int DSC_SCAN_CNT_W = 24;

    localparam int DSC_TIME_W = 11;
    localparam int DSC_ACC_W = 12;
    localparam logic [DSC_ACC_W-1:0] DSC_SCAN_STEP_MS = 12'h032;

    // word indices inside one instance window
    localparam logic [3:0] DSC_W_CFG = 4'h0;
    localparam logic [3:0] DSC_W_OPER = 4'h1;
    localparam logic [3:0] DSC_W_DISC = 4'h2;
    localparam logic [3:0] DSC_W_STAT = 4'h3;
    localparam logic [3:0] DSC_W_CNT = 4'h4;
    localparam logic [3:0] DSC_W_NAME0 = 4'h5;
    localparam int DSC_NAME_WORDS = 5;
    localparam int DSC_LONG_WORDS = 3;

    localparam int DSC_CFG_W = 5;
    localparam int DSC_CFG_EN = 0;
    localparam int DSC_CFG_SUBST = 1;
    localparam int DSC_CFG_SUBVAL = 2;
    localparam int DSC_CFG_1POLE = 3;
    localparam int DSC_CFG_EVT = 4;
    localparam logic [DSC_CFG_W-1:0] DSC_CFG_RST = 5'h11;
    localparam logic [DSC_TIME_W-1:0] DSC_OPER_RST = 11'h046;
    localparam logic [DSC_TIME_W-1:0] DSC_DISC_RST = 11'h046;
    localparam logic [31:0] DSC_NAME_RST = 32'h0000_0000;
    localparam int DSC_CNT_W = 16;

    typedef struct packed {
        logic [2:0] closed;
        logic [2:0] opened;
        logic blk_close;
        logic blk_open;
        logic local_in;
        logic cnt_rst;
        logic open_req;
        logic close_req;
    } dsc_pins_s;

    typedef struct packed {
        logic closed;
        logic opened;
        logic bad;
        logic disc;
        logic open_cmd;
        logic close_cmd;
        logic ev_valid;
        logic [3:0] ev_code;
    } dsc_out_s;

    typedef struct packed {
        logic [DSC_ACC_W-1:0] acc;
        logic expired;
    } dsc_tmr_s;

endpackage

// *** design/dsc_scan_timer.sv ***
// scan-stepped elapsed-time timer for one switch condition
// assumes step is a one-cycle pulse once per automation scan
`timescale 1ns/1ps
module dsc_scan_timer
    import dsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic step,
    input wire logic run,
    input wire logic [DSC_TIME_W-1:0] limit,
    output logic expired
);
    dsc_tmr_s st;
    dsc_tmr_s next_st;
    logic [DSC_ACC_W-1:0] lim_w;

    assign lim_w = {1'b0, limit};
    assign expired = st.expired;

    always_comb
    begin
        next_st = st;
        if (step)
        begin
            if (!run)
            begin
                next_st.acc = '0;
                next_st.expired = 1'b0;
            end
            else
            begin
                // a zero setting expires on the first scan that sees the condition
                next_st.expired = (st.acc >= lim_w);
                if (st.acc < lim_w)
                begin
                    next_st.acc = st.acc + DSC_SCAN_STEP_MS;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// *** design/dsc_ctrl.sv ***
// disconnect status and control for all switch instances
// assumes contact and operand inputs are asynchronous to core_clk
// assumes register master issues single-cycle strobes, never both at once
`timescale 1ns/1ps
module dsc_ctrl
    import dsc_pkg::*;
#(
    parameter int N = DSC_N,
    parameter int SCAN_CYCLES = DSC_SCAN_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [DSC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire dsc_pins_s [N-1:0] pins,
    output dsc_out_s [N-1:0] sw_out
);
    typedef struct packed {
        logic [DSC_CFG_W-1:0] cfg;
        logic [DSC_TIME_W-1:0] oper_ms;
        logic [DSC_TIME_W-1:0] disc_ms;
        logic [DSC_NAME_WORDS-1:0][31:0] name;
        dsc_pins_s smp;
        logic res_closed;
        logic res_opened;
        logic res_bad;
        logic res_disc;
        logic res_open_cmd;
        logic res_close_cmd;
        logic [DSC_CNT_W-1:0] open_cnt;
        logic [DSC_CNT_W-1:0] close_cnt;
        dsc_out_s out;
    } dsc_inst_s;

    typedef struct packed {
        dsc_pins_s [N-1:0] sync1;
        dsc_pins_s [N-1:0] sync2;
        logic [DSC_SCAN_CNT_W-1:0] scan_cnt;
        logic proc_pulse;
        logic out_pulse;
        logic [31:0] rdata;
        dsc_inst_s [N-1:0] inst;
    } dsc_state_s;

    localparam logic [DSC_SCAN_CNT_W-1:0] SCAN_LAST = DSC_SCAN_CNT_W'(SCAN_CYCLES - 1);

    dsc_state_s st;
    dsc_state_s next_st;

    logic [N-1:0] run_bad;
    logic [N-1:0] run_disc;
    logic [N-1:0] pos_closed;
    logic [N-1:0] pos_opened;
    logic [N-1:0] exp_bad;
    logic [N-1:0] exp_disc;
    logic [N-1:0] cmd_open;
    logic [N-1:0] cmd_close;

    logic scan_tick;
    logic [2:0] sel_inst;
    logic [3:0] sel_word;
    logic sel_ok;

    assign scan_tick = (st.scan_cnt == SCAN_LAST);
    assign sel_inst = reg_addr[DSC_INST_LSB+2:DSC_INST_LSB];
    assign sel_word = reg_addr[DSC_INST_LSB-1:2];
    assign sel_ok = (32'(sel_inst) < N);

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_sw
            logic en;
            logic one_pole;
            logic [2:0] mask;
            logic [2:0] ph_c;
            logic [2:0] ph_o;
            logic [2:0] ph_none;
            logic all_c;
            logic all_o;

            assign en = st.inst[gi].cfg[DSC_CFG_EN];
            assign one_pole = st.inst[gi].cfg[DSC_CFG_1POLE];
            // three-pole looks at phase A only
            assign mask = one_pole ? 3'h7 : 3'h1;
            // an absent open contact is assumed fed as the inverted closed operand
            assign ph_c = st.inst[gi].smp.closed & ~st.inst[gi].smp.opened;
            assign ph_o = st.inst[gi].smp.opened & ~st.inst[gi].smp.closed;
            assign ph_none = ~st.inst[gi].smp.closed & ~st.inst[gi].smp.opened & mask;
            assign all_c = ((ph_c & mask) == mask);
            assign all_o = ((ph_o & mask) == mask);

            assign run_bad[gi] = en & (|ph_none);
            assign run_disc[gi] = en & one_pole & ~all_c & ~all_o;

            always_comb
            begin
                if (st.inst[gi].cfg[DSC_CFG_SUBST])
                begin
                    pos_closed[gi] = st.inst[gi].cfg[DSC_CFG_SUBVAL];
                    pos_opened[gi] = ~st.inst[gi].cfg[DSC_CFG_SUBVAL];
                end
                else
                begin
                    pos_closed[gi] = all_c;
                    pos_opened[gi] = all_o;
                end
            end

            assign cmd_close[gi] = en & st.inst[gi].smp.close_req & ~st.inst[gi].smp.blk_close
                                   & ~st.inst[gi].smp.local_in;
            assign cmd_open[gi] = en & st.inst[gi].smp.open_req & ~st.inst[gi].smp.blk_open
                                  & ~st.inst[gi].smp.local_in;

            dsc_scan_timer u_oper_tmr
            (
                .core_clk(core_clk),
                .rst(rst),
                .step(st.proc_pulse),
                .run(run_bad[gi]),
                .limit(st.inst[gi].oper_ms),
                .expired(exp_bad[gi])
            );

            dsc_scan_timer u_disc_tmr
            (
                .core_clk(core_clk),
                .rst(rst),
                .step(st.proc_pulse),
                .run(run_disc[gi]),
                .limit(st.inst[gi].disc_ms),
                .expired(exp_disc[gi])
            );
        end
    endgenerate

    assign reg_rdata = st.rdata;
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            sw_out[i] = st.inst[i].out;
        end
    end

    always_comb
    begin
        logic en;
        logic [3:0] code;
        logic [3:0] prev;
        en = 1'b0;
        code = '0;
        prev = '0;
        next_st = st;

        // two-stage synchroniser, first stage read only by the second
        next_st.sync1 = pins;
        next_st.sync2 = st.sync1;

        next_st.scan_cnt = scan_tick ? '0 : st.scan_cnt + 1'b1;
        // process one cycle after sampling, outputs one cycle after processing
        next_st.proc_pulse = scan_tick;
        next_st.out_pulse = st.proc_pulse;

        for (int i = 0; i < N; i++)
        begin
            en = st.inst[i].cfg[DSC_CFG_EN];
            next_st.inst[i].out.ev_valid = 1'b0;

            if (scan_tick)
            begin
                next_st.inst[i].smp = st.sync2[i];
            end

            if (st.proc_pulse)
            begin
                // timers are stepped by this same pulse and are read at the output stage
                next_st.inst[i].res_closed = en & pos_closed[i];
                next_st.inst[i].res_opened = en & pos_opened[i];
                next_st.inst[i].res_open_cmd = cmd_open[i];
                next_st.inst[i].res_close_cmd = cmd_close[i];
                if (st.inst[i].smp.cnt_rst)
                begin
                    next_st.inst[i].open_cnt = '0;
                    next_st.inst[i].close_cnt = '0;
                end
                else if (en)
                begin
                    // counts transitions of the presented position, substituted or not
                    if (pos_closed[i] && !st.inst[i].out.closed)
                    begin
                        next_st.inst[i].close_cnt = st.inst[i].close_cnt + 1'b1;
                    end
                    if (pos_opened[i] && !st.inst[i].out.opened)
                    begin
                        next_st.inst[i].open_cnt = st.inst[i].open_cnt + 1'b1;
                    end
                end
            end

            if (st.out_pulse)
            begin
                code = {en & exp_bad[i], en & exp_disc[i], st.inst[i].res_closed, st.inst[i].res_opened};
                prev = {st.inst[i].out.bad, st.inst[i].out.disc, st.inst[i].out.closed,
                        st.inst[i].out.opened};
                next_st.inst[i].out.closed = st.inst[i].res_closed;
                next_st.inst[i].out.opened = st.inst[i].res_opened;
                next_st.inst[i].out.bad = en & exp_bad[i];
                // timer restarts once poles agree, so the flag drops on that scan
                next_st.inst[i].out.disc = en & exp_disc[i];
                next_st.inst[i].out.open_cmd = st.inst[i].res_open_cmd;
                next_st.inst[i].out.close_cmd = st.inst[i].res_close_cmd;
                if (code != prev)
                begin
                    next_st.inst[i].out.ev_valid = en & st.inst[i].cfg[DSC_CFG_EVT];
                    next_st.inst[i].out.ev_code = code;
                end
                // a stale code would leave a disabled switch showing activity
                if (!en)
                begin
                    next_st.inst[i].out.ev_code = '0;
                end
            end
        end

        // register write port
        if (reg_we && sel_ok)
        begin
            case (sel_word)
                DSC_W_CFG:
                begin
                    next_st.inst[sel_inst].cfg = reg_wdata[DSC_CFG_W-1:0];
                end
                DSC_W_OPER:
                begin
                    next_st.inst[sel_inst].oper_ms = reg_wdata[DSC_TIME_W-1:0];
                end
                DSC_W_DISC:
                begin
                    next_st.inst[sel_inst].disc_ms = reg_wdata[DSC_TIME_W-1:0];
                end
                default:
                begin
                    if (sel_word >= DSC_W_NAME0 && sel_word < DSC_W_NAME0 + 4'(DSC_NAME_WORDS))
                    begin
                        // words 0..2 long name, 3..4 short name, four characters a word
                        next_st.inst[sel_inst].name[sel_word - DSC_W_NAME0] = reg_wdata;
                    end
                end
            endcase
        end

        // read data stands only in the cycle after the strobe
        next_st.rdata = '0;
        if (reg_re && sel_ok)
        begin
            case (sel_word)
                DSC_W_CFG:
                begin
                    next_st.rdata = 32'(st.inst[sel_inst].cfg);
                end
                DSC_W_OPER:
                begin
                    next_st.rdata = 32'(st.inst[sel_inst].oper_ms);
                end
                DSC_W_DISC:
                begin
                    next_st.rdata = 32'(st.inst[sel_inst].disc_ms);
                end
                DSC_W_STAT:
                begin
                    next_st.rdata = {20'h00000, st.inst[sel_inst].smp.closed, st.inst[sel_inst].smp.opened,
                                     st.inst[sel_inst].out.close_cmd, st.inst[sel_inst].out.open_cmd,
                                     st.inst[sel_inst].out.disc, st.inst[sel_inst].out.bad,
                                     st.inst[sel_inst].out.opened, st.inst[sel_inst].out.closed};
                end
                DSC_W_CNT:
                begin
                    next_st.rdata = {st.inst[sel_inst].close_cnt, st.inst[sel_inst].open_cnt};
                end
                default:
                begin
                    if (sel_word >= DSC_W_NAME0 && sel_word < DSC_W_NAME0 + 4'(DSC_NAME_WORDS))
                    begin
                        next_st.rdata = st.inst[sel_inst].name[sel_word - DSC_W_NAME0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            for (int i = 0; i < N; i++)
            begin
                st.inst[i].cfg <= DSC_CFG_RST;
                st.inst[i].oper_ms <= DSC_OPER_RST;
                st.inst[i].disc_ms <= DSC_DISC_RST;
                st.inst[i].name <= {DSC_NAME_WORDS{DSC_NAME_RST}};
            end
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// *** tb/dsc_checker.sv ***
// port assertions for the disconnect block, instance 0
// assumes bound into dsc_ctrl with its own parameters
`timescale 1ns/1ps
module dsc_checker
    import dsc_pkg::*;
#(
    parameter int N = DSC_N,
    parameter int SCAN_CYCLES = DSC_SCAN_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire dsc_pins_s [N-1:0] pins,
    input wire dsc_out_s [N-1:0] sw_out
);
    // sync flops plus two scans of wait plus output stage
    localparam int LAT = 2 * SCAN_CYCLES + 4;
    typedef struct packed {
        logic [15:0] cb, ob, lc, sc;
        logic [5:0] lv;
    } dsc_chk_s;
    dsc_chk_s st;
    dsc_chk_s next_st;
    always_comb
    begin
        next_st = st;
        next_st.cb = pins[0].blk_close ? st.cb + 16'h0001 : 16'h0000;
        next_st.ob = pins[0].blk_open ? st.ob + 16'h0001 : 16'h0000;
        next_st.lc = pins[0].local_in ? st.lc + 16'h0001 : 16'h0000;
        next_st.lv = sw_out[0][10:5];
        next_st.sc = (sw_out[0][10:5] != st.lv) ? 16'h0000 : st.sc + 16'h0001;
    end
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (rst);
    a_close_blocked: assert property (st.cb > LAT |-> !sw_out[0].close_cmd)
        else $error("close command while close blocked");
    a_open_blocked: assert property (st.ob > LAT |-> !sw_out[0].open_cmd)
        else $error("open command while open blocked");
    a_local_inhibit: assert property (st.lc > LAT |-> !sw_out[0].open_cmd && !sw_out[0].close_cmd)
        else $error("command while local input high");
    a_pos_exclusive: assert property (sw_out[0].closed |-> !sw_out[0].opened)
        else $error("closed and opened together");
    a_disc_position: assert property (sw_out[0].disc |-> !sw_out[0].closed && !sw_out[0].opened)
        else $error("discrepancy with agreeing poles");
    a_event_code: assert property (sw_out[0].ev_valid |-> sw_out[0].ev_code ==
        {sw_out[0].bad, sw_out[0].disc, sw_out[0].closed, sw_out[0].opened})
        else $error("event code differs from indications");
    a_event_pulse: assert property (sw_out[0].ev_valid |=> !sw_out[0].ev_valid)
        else $error("event pulse longer than one cycle");
    a_scan_spacing: assert property (sw_out[0][10:5] != st.lv |-> st.sc >= SCAN_CYCLES - 1)
        else $error("outputs changed twice within one scan");
    c_event: cover property (sw_out[0].ev_valid);
    c_bad: cover property (sw_out[0].bad);
    c_disc: cover property (sw_out[0].disc);
endmodule
bind dsc_ctrl dsc_checker #(.N(N), .SCAN_CYCLES(SCAN_CYCLES)) dsc_checker_i (
    .core_clk(core_clk), .rst(rst), .pins(pins), .sw_out(sw_out));

// *** tb/dsc_contacts.sv ***
// auxiliary contacts of one disconnect, one pole per phase
// assumes commands are the block's command levels
`timescale 1ns/1ps
module dsc_contacts #(
    parameter int FAST = 5,
    parameter int SLOW = 400,
    parameter bit NO_NC = 1'b0
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic go_close,
    input wire logic go_open,
    input wire logic slow,
    input wire logic [2:0] hold,
    output logic [2:0] closed,
    output logic [2:0] opened
);
    logic [2:0] pos;
    logic [2:0] mv;
    int tm [3];
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pos <= 3'h0;
            mv <= 3'h0;
        end
        else
        begin
            for (int p = 0; p < 3; p++)
            begin
                // a held pole is stuck, the fault the bench injects
                if (!hold[p] && mv[p])
                begin
                    tm[p] <= tm[p] - 1;
                    if (tm[p] == 0)
                    begin
                        mv[p] <= 1'b0;
                        pos[p] <= ~pos[p];
                    end
                end
                else if (!hold[p] && (go_close && !pos[p] || go_open && pos[p]))
                begin
                    mv[p] <= 1'b1;
                    tm[p] <= slow ? SLOW : FAST * (p + 1);
                end
            end
        end
    end
    // both contacts low while a pole travels with NO_NC clear, opened high with NO_NC set
    assign closed = pos & ~mv;
    assign opened = NO_NC ? ~closed : ~pos & ~mv;
endmodule

// *** tb/dsc_ctrl_tb.sv ***
// self-checking bench for dsc_ctrl, instance 0 on a contact model
// assumes short scan of SC cycles, timers still step 50 ms a scan
`timescale 1ns/1ps
module dsc_ctrl_tb;
    import dsc_pkg::*;
    localparam int SC = 20;
    logic core_clk;
    logic rst;
    logic [DSC_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_we;
    logic reg_re;
    logic [31:0] reg_rdata;
    dsc_pins_s [1:0] pins;
    dsc_out_s [1:0] sw_out;
    dsc_pins_s ctl0;
    dsc_pins_s ctl1;
    logic slow;
    logic [2:0] hold;
    logic [2:0] cl;
    logic [2:0] op;
    int failures = 0;
    int checked = 0;
    int evn = 0;
    int snap;
    // open_req close_req blk_open blk_close local_in | open_cmd close_cmd
    logic [6:0] rows [8] = '{7'b0100001, 7'b0101000, 7'b1001010, 7'b1010000,
        7'b0110001, 7'b1100100, 7'b1000100, 7'b0000000};
    always_comb
    begin
        pins[1] = ctl1;
        pins[0] = ctl0;
        pins[0].closed = cl;
        pins[0].opened = op;
    end
    always @(posedge core_clk)
    begin
        if (sw_out[0].ev_valid === 1'b1)
            evn <= evn + 1;
    end
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    dsc_ctrl #(.N(2), .SCAN_CYCLES(SC)) dsc_ctrl_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pins(pins),
        .sw_out(sw_out));
    dsc_contacts dsc_contacts_i (.core_clk(core_clk), .rst(rst), .go_close(sw_out[0].close_cmd),
        .go_open(sw_out[0].open_cmd), .slow(slow), .hold(hold), .closed(cl), .opened(op));
    task automatic conclude;
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_b(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask
    task automatic rdc(input logic [8:0] a, input logic [31:0] e, input string nm);
        @(posedge core_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1;
        chk_w(nm, e, reg_rdata);
    endtask
    task automatic scans(input int n);
        repeat (n * SC) @(posedge core_clk);
    endtask
    task automatic wait_closed;
        int i;
        for (i = 0; i < 40 * SC && sw_out[0].closed !== 1'b1; i++)
            @(posedge core_clk);
        chk_b("closed in time", 1'b1, sw_out[0].closed);
        if (i == 40 * SC)
            conclude();
    endtask
    initial
    begin
        rst = 1'b1;
        {reg_addr, reg_wdata, reg_we, reg_re} = '0;
        ctl0 = '0;
        ctl1 = '0;
        ctl1.closed = 3'h1;
        slow = 1'b0;
        hold = 3'h0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rdc(9'h000, 32'h0000_0011, "cfg");
        rdc(9'h004, 32'h0000_0046, "oper");
        rdc(9'h008, 32'h0000_0046, "disc");
        rdc(9'h040, 32'h0000_0011, "cfg1");
        rdc(9'h03C, 32'h0000_0000, "unmapped");
        wr(9'h080, 32'hFFFF_FFFF);
        rdc(9'h080, 32'h0000_0000, "no instance");
        wr(9'h01C, 32'h3132_3334);
        wr(9'h024, 32'h4142_4344);
        rdc(9'h01C, 32'h3132_3334, "long name");
        rdc(9'h024, 32'h4142_4344, "short name");
        rdc(9'h05C, 32'h0000_0000, "long name1");
        wr(9'h004, 32'h0000_0046);
        wr(9'h008, 32'h0000_0046);
        scans(3);
        chk_b("opened", 1'b1, sw_out[0].opened);
        chk_b("closed1", 1'b1, sw_out[1].closed);
        ctl0.cnt_rst <= 1'b1;
        scans(3);
        ctl0.cnt_rst <= 1'b0;
        rdc(9'h010, 32'h0000_0000, "cnt cleared");
        // slow travel leaves both contacts low for many scans
        slow <= 1'b1;
        ctl0.close_req <= 1'b1;
        scans(6);
        chk_b("bad", 1'b1, sw_out[0].bad);
        wait_closed();
        ctl0.close_req <= 1'b0;
        slow <= 1'b0;
        scans(2);
        chk_b("bad clear", 1'b0, sw_out[0].bad);
        rdc(9'h010, 32'h0001_0000, "cnt close");
        foreach (rows[k])
        begin
            {ctl0.open_req, ctl0.close_req, ctl0.blk_open, ctl0.blk_close, ctl0.local_in} <= rows[k][6:2];
            scans(3);
            chk_b("open_cmd", rows[k][1], sw_out[0].open_cmd);
            chk_b("close_cmd", rows[k][0], sw_out[0].close_cmd);
        end
        wr(9'h000, 32'h0000_0001);
        snap = evn;
        ctl0.open_req <= 1'b1;
        scans(4);
        ctl0.open_req <= 1'b0;
        chk_w("events off", snap, evn);
        wr(9'h000, 32'h0000_0011);
        ctl0.close_req <= 1'b1;
        scans(4);
        ctl0.close_req <= 1'b0;
        chk_b("events on", 1'b1, evn > snap);
        hold <= 3'b100;
        ctl0.open_req <= 1'b1;
        scans(3);
        chk_b("3p opened", 1'b1, sw_out[0].opened);
        chk_b("3p disc", 1'b0, sw_out[0].disc);
        wr(9'h000, 32'h0000_0019);
        scans(6);
        chk_b("1p disc", 1'b1, sw_out[0].disc);
        chk_b("1p opened", 1'b0, sw_out[0].opened);
        hold <= 3'h0;
        scans(3);
        chk_b("disc clear", 1'b0, sw_out[0].disc);
        chk_b("1p all open", 1'b1, sw_out[0].opened);
        ctl0.open_req <= 1'b0;
        wr(9'h000, 32'h0000_0017);
        scans(3);
        chk_b("subst closed", 1'b1, sw_out[0].closed);
        chk_b("subst opened", 1'b0, sw_out[0].opened);
        rdc(9'h00C, 32'h0000_01C1, "stat");
        wr(9'h000, 32'h0000_0010);
        ctl0.close_req <= 1'b1;
        scans(3);
        chk_w("disabled", 32'h0, {21'h0, sw_out[0]});
        chk_b("closed1 kept", 1'b1, sw_out[1].closed);
        conclude();
    end
endmodule
